// [rtl/ifd_pkg.sv]
// Shared constants, types and decode helpers of the instruction fetch and dispatch unit.
// Assumes one core clock; instruction words use the simple field layout below.
package ifd_pkg;
  localparam int IQ_DEPTH  = 6;
  localparam int FETCH_MAX = 2;
  localparam int ISSUE_MAX = 2;
  localparam int CQ_DEPTH  = 5;
  localparam int N_STATION = 5;
  localparam int PEEK      = 3;

  localparam int CLS_MSB  = 31;
  localparam int CLS_LSB  = 29;
  localparam int PRED_BIT = 28;
  localparam int SER_BIT  = 27;
  localparam int DST_MSB  = 26;
  localparam int SRCA_MSB = 21;
  localparam int SRCB_MSB = 16;
  localparam int OFF_MSB  = 11;

  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0004;

  localparam logic [2:0] RS_INT0 = 3'h0;
  localparam logic [2:0] RS_INT1 = 3'h1;
  localparam logic [2:0] RS_FLT  = 3'h2;
  localparam logic [2:0] RS_LDST = 3'h3;
  localparam logic [2:0] RS_SYS  = 3'h4;

  typedef enum logic [2:0] {
    CLS_INT    = 3'b000,
    CLS_FLOAT  = 3'b001,
    CLS_LDST   = 3'b010,
    CLS_SYSREG = 3'b011,
    CLS_JUMP   = 3'b100,
    CLS_CBR    = 3'b101
  } ifd_cls_t;

  typedef enum logic [0:0] {
    ST_FIRM = 1'b0,
    ST_SPEC = 1'b1
  } ifd_state_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] word;
  } ifd_entry_t;

  typedef struct packed {
    logic        valid;
    logic        spec;
    logic [2:0]  station;
    logic [31:0] pc;
    logic [31:0] word;
  } ifd_disp_t;

  // Returns {found, station}; taken marks a station already used this cycle
  function automatic logic [3:0] pick_station(input logic [2:0] cls,
                                              input logic [4:0] rdy,
                                              input logic [4:0] taken);
    logic [4:0] free;
    free = rdy & ~taken;
    case (cls)
      CLS_INT:    pick_station = free[RS_INT0] ? {1'b1, RS_INT0} : {free[RS_INT1], RS_INT1};
      CLS_FLOAT:  pick_station = {free[RS_FLT], RS_FLT};
      CLS_LDST:   pick_station = {free[RS_LDST], RS_LDST};
      CLS_SYSREG: pick_station = {free[RS_SYS], RS_SYS};
      default:    pick_station = 4'h0;
    endcase
  endfunction
endpackage

// [rtl/ifd_queue.sv]
// Instruction holding queue: circular buffer, up to two writes and three reads a cycle.
// Assumes the caller never pushes beyond free space nor pops beyond the count.
`timescale 1ns/1ps
module ifd_queue #(
  parameter int DEPTH = ifd_pkg::IQ_DEPTH
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n,
  input  wire logic                              flush_i,
  input  wire logic [1:0]                        push_cnt_i,
  input  wire ifd_pkg::ifd_entry_t [ifd_pkg::FETCH_MAX-1:0] push_i,
  input  wire logic [1:0]                        pop_cnt_i,
  output      ifd_pkg::ifd_entry_t [ifd_pkg::PEEK-1:0]      head_o,
  output      logic [2:0]                        count_o
);
  import ifd_pkg::*;
  localparam int PW = $clog2(DEPTH);

  ifd_entry_t         mem [DEPTH];
  logic [PW-1:0]      head;
  logic [PW-1:0]      tail;

  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p, input int k);
    int s;
    s = int'(p) + k;
    if (s >= DEPTH) begin
      s = s - DEPTH;
    end
    return PW'(s);
  endfunction

  assign tail = wrap(head, int'(count_o));

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      head    <= '0;
      count_o <= '0;
    end else if (flush_i) begin
      head    <= '0;
      count_o <= '0;
    end else begin
      head    <= wrap(head, int'(pop_cnt_i));
      count_o <= count_o + 3'(push_cnt_i) - 3'(pop_cnt_i);
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < FETCH_MAX; i++) begin
      if (!flush_i && i < int'(push_cnt_i)) begin
        mem[wrap(tail, i)] <= push_i[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < PEEK; g++) begin : g_peek
      assign head_o[g] = mem[wrap(head, g)];
    end
  endgenerate
endmodule

// [rtl/ifd_dep_check.sv]
// Register hazard and serialization check for one dispatch slot.
// Assumes busy vectors come from the rename logic of the execution side.
`timescale 1ns/1ps
module ifd_dep_check (
  input  wire logic [31:0] word_i,
  input  wire logic        prior_valid_i,
  input  wire logic [31:0] prior_word_i,
  input  wire logic [31:0] gpr_busy_i,
  input  wire logic [31:0] fpr_busy_i,
  output      logic        clear_o,
  output      logic        serial_o
);
  import ifd_pkg::*;
  logic [4:0]  dst;
  logic [4:0]  srca;
  logic [4:0]  srcb;
  logic [4:0]  pdst;
  logic        is_flt;
  logic        same_file;
  logic [31:0] busy;
  logic        busy_hit;
  logic        prior_hit;

  assign dst       = word_i[DST_MSB -: 5];
  assign srca      = word_i[SRCA_MSB -: 5];
  assign srcb      = word_i[SRCB_MSB -: 5];
  assign pdst      = prior_word_i[DST_MSB -: 5];
  assign is_flt    = word_i[CLS_MSB:CLS_LSB] == CLS_FLOAT;
  assign same_file = is_flt == (prior_word_i[CLS_MSB:CLS_LSB] == CLS_FLOAT);
  assign busy      = is_flt ? fpr_busy_i : gpr_busy_i;
  assign busy_hit  = busy[srca] | busy[srcb] | busy[dst];
  assign prior_hit = prior_valid_i & same_file & (pdst == srca | pdst == srcb | pdst == dst);
  assign clear_o   = !busy_hit && !prior_hit;
  assign serial_o  = word_i[SER_BIT];
endmodule

// [rtl/ifd_top.sv]
// Instruction unit: fetch addressing, holding queue, branch folding and dual dispatch.
// Assumes icache answers with the address it was given; stations raise ready when free.
`timescale 1ns/1ps

// Notes on behaviour
// - The holding queue keeps at most six instructions for lookahead.
// - At most two fetched instructions enter the queue per cycle.
// - Fetch keeps requesting while entries stay free after this cycle's accepts, not counting its pops.
// - At most two instructions are dispatched per cycle.
// - Every dispatched instruction targets one ready reservation station.
// - Register hazards and serialization stall dispatch of later instructions.
// - Next fetch address is sequential or the resolver's target.
// - Unresolved conditional branches are predicted; fetch follows the prediction.
// - Branches with known outcome are folded out, using no execution slot.
// - Instructions past a predicted branch cannot complete until it resolves.
// - Branches on a speculative path are decoded but held, not issued.
// - Speculative work stops before write-back; released when prediction was right.
// - A mispredict discards predicted-path work and resumes on the right path.
// - Per clock at most two non-branch instructions plus one branch.
// - At most five instructions are in execution at once.
// - The fetch path takes up to two icache instructions per clock.
// - Predicted direction comes from a bit in the branch encoding.
// - Dispatch stalls when the five-entry completion queue is full.
module ifd_top (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    ic_valid_i,
  input  wire logic [1:0]              ic_cnt_i,
  input  wire logic [31:0]             ic_addr_i,
  input  wire logic [1:0][31:0]        ic_word_i,
  output      logic                    fetch_req_o,
  output      logic [31:0]             fetch_addr_o,
  input  wire logic [4:0]              rs_ready_i,
  input  wire logic [31:0]             gpr_busy_i,
  input  wire logic [31:0]             fpr_busy_i,
  input  wire logic                    cond_busy_i,
  input  wire logic                    cond_true_i,
  input  wire logic                    resolve_valid_i,
  input  wire logic                    resolve_taken_i,
  input  wire logic [1:0]              retire_cnt_i,
  output      ifd_pkg::ifd_disp_t [1:0] disp_o,
  output      logic                    wb_hold_o,
  output      logic                    flush_o
);
  import ifd_pkg::*;

  logic                    rst_meta;
  logic                    rst_n;
  ifd_entry_t [PEEK-1:0]   head;
  ifd_entry_t [1:0]        push;
  logic [2:0]              q_cnt;
  logic [2:0]              q_free;
  logic [1:0]              ic_cnt_c;
  logic                    ic_hit;
  logic [1:0]              n_acc;
  ifd_state_t              state;
  ifd_state_t              next_state;
  logic                    pend_pred;
  logic [31:0]             alt_pc;
  logic [2:0]              cq_cnt;
  logic [2:0]              cq_free;
  logic [2:0]              spec_cnt;
  logic [1:0]              clear;
  logic [1:0]              serial;
  logic [1:0]              is_br;
  logic [3:0]              st0;
  logic [3:0]              st1;
  logic                    d0;
  logic                    d1;
  logic [1:0]              disp_n;
  logic [1:0]              bpos;
  ifd_entry_t              b_ent;
  logic                    b_go;
  logic                    b_cond;
  logic                    b_unres;
  logic                    b_taken;
  logic [31:0]             b_tgt;
  logic [31:0]             b_seq;
  logic                    res_ok;
  logic                    mis;
  logic                    redir;
  logic [31:0]             redir_pc;
  logic                    spec_now;
  logic [1:0]              pop_cnt;
  logic [31:0]             next_pc;
  logic [2:0]              next_cq;
  logic [2:0]              next_spec_cnt;
  ifd_disp_t [1:0]         next_disp;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Fetch acceptance; stale answers for an old address are dropped
  assign q_free   = 3'(IQ_DEPTH) - q_cnt;
  assign ic_cnt_c = (ic_cnt_i > 2'(FETCH_MAX)) ? 2'(FETCH_MAX) : ic_cnt_i;
  assign ic_hit   = ic_valid_i && ic_addr_i == fetch_addr_o && !redir;
  assign n_acc    = !ic_hit ? 2'h0 : ({1'b0, ic_cnt_c} > q_free) ? q_free[1:0] : ic_cnt_c;

  genvar k;
  generate
    for (k = 0; k < FETCH_MAX; k++) begin : g_push
      assign push[k].pc   = ic_addr_i + INSN_BYTES * 32'(k);
      assign push[k].word = ic_word_i[k];
    end
    for (k = 0; k < ISSUE_MAX; k++) begin : g_dep
      ifd_dep_check u_dep (
        .word_i        (head[k].word),
        .prior_valid_i (k != 0),
        .prior_word_i  (head[0].word),
        .gpr_busy_i    (gpr_busy_i),
        .fpr_busy_i    (fpr_busy_i),
        .clear_o       (clear[k]),
        .serial_o      (serial[k])
      );
      assign is_br[k] = head[k].word[CLS_MSB];
    end
  endgenerate

  ifd_queue u_queue (
    .clk_i      (clk_i),
    .rst_n      (rst_n),
    .flush_i    (redir),
    .push_cnt_i (n_acc),
    .push_i     (push),
    .pop_cnt_i  (pop_cnt),
    .head_o     (head),
    .count_o    (q_cnt)
  );

  // Dispatch from the two oldest entries only
  assign cq_free = 3'(CQ_DEPTH) - cq_cnt;
  assign st0     = pick_station(head[0].word[CLS_MSB:CLS_LSB], rs_ready_i, 5'h00);
  assign st1     = pick_station(head[1].word[CLS_MSB:CLS_LSB], rs_ready_i,
                                5'(5'h01 << st0[2:0]));
  assign d0 = !mis && q_cnt != 3'h0 && !is_br[0] && clear[0] && st0[3]
              && cq_free != 3'h0 && (!serial[0] || cq_cnt == 3'h0);
  assign d1 = d0 && q_cnt > 3'h1 && !is_br[1] && clear[1] && st1[3]
              && cq_free > 3'h1 && !serial[0] && !serial[1];
  assign disp_n = 2'(d0) + 2'(d1);

  // Branch resolver works on the first entry not taken by dispatch
  assign bpos    = disp_n;
  assign b_ent   = head[bpos];
  assign b_go    = q_cnt > 3'(bpos) && b_ent.word[CLS_MSB] && state == ST_FIRM;
  assign b_cond  = b_ent.word[CLS_MSB:CLS_LSB] == CLS_CBR;
  assign b_unres = b_cond && cond_busy_i;
  assign b_taken = !b_cond ? 1'b1 : b_unres ? b_ent.word[PRED_BIT] : cond_true_i;
  assign b_tgt   = b_ent.pc + {{18{b_ent.word[OFF_MSB]}}, b_ent.word[OFF_MSB:0], 2'b00};
  assign b_seq   = b_ent.pc + INSN_BYTES;
  assign pop_cnt = disp_n + 2'(b_go);

  assign res_ok   = state == ST_SPEC && resolve_valid_i && resolve_taken_i == pend_pred;
  assign mis      = state == ST_SPEC && resolve_valid_i && resolve_taken_i != pend_pred;
  assign spec_now = state == ST_SPEC && !res_ok;
  assign redir    = mis || (b_go && b_taken);
  assign redir_pc = mis ? alt_pc : b_tgt;
  assign next_pc  = redir ? redir_pc : fetch_addr_o + {28'h0, n_acc, 2'b00};

  always_comb begin
    case (state)
      ST_FIRM: next_state = (b_go && b_unres) ? ST_SPEC : ST_FIRM;
      ST_SPEC: next_state = resolve_valid_i ? ST_FIRM : ST_SPEC;
      default: next_state = ST_FIRM;
    endcase
  end

  // Completion queue occupancy; discarded speculative work leaves it on a mispredict
  assign next_cq = cq_cnt + 3'(disp_n) - 3'(retire_cnt_i) - (mis ? spec_cnt : 3'h0);
  assign next_spec_cnt = spec_now ? spec_cnt + 3'(disp_n) : 3'h0;

  assign next_disp[0] = '{valid: d0, spec: spec_now, station: st0[2:0],
                          pc: head[0].pc, word: head[0].word};
  assign next_disp[1] = '{valid: d1, spec: spec_now, station: st1[2:0],
                          pc: head[1].pc, word: head[1].word};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_FIRM;
      pend_pred    <= 1'b0;
      alt_pc       <= RESET_PC;
      fetch_addr_o <= RESET_PC;
      fetch_req_o  <= 1'b0;
      cq_cnt       <= 3'h0;
      spec_cnt     <= 3'h0;
      disp_o       <= '0;
      wb_hold_o    <= 1'b0;
      flush_o      <= 1'b0;
    end else begin
      state        <= next_state;
      fetch_addr_o <= next_pc;
      fetch_req_o  <= redir || q_free > 3'(n_acc);
      cq_cnt       <= next_cq;
      spec_cnt     <= next_spec_cnt;
      disp_o       <= next_disp;
      wb_hold_o    <= next_state == ST_SPEC;
      flush_o      <= mis;
      if (b_go && b_unres) begin
        pend_pred <= b_taken;
        alt_pc    <= b_taken ? b_seq : b_tgt;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_queue_bound: assert property (q_cnt <= 3'(IQ_DEPTH))
    else $error("holding queue above six");
  a_push_limit: assert property (n_acc <= 2'(FETCH_MAX) && 3'(n_acc) <= q_free)
    else $error("too many instructions pushed");
  a_fetch_keeps: assert property (q_cnt == 3'h0 |=> fetch_req_o)
    else $error("fetch idle with empty queue");
  a_disp_order: assert property (disp_o[1].valid |-> disp_o[0].valid)
    else $error("second slot without first");
  a_station_pair: assert property (disp_o[0].valid && disp_o[1].valid
                                   |-> disp_o[0].station != disp_o[1].station)
    else $error("two instructions on one station");
  a_serial_alone: assert property (d0 && serial[0] |-> cq_cnt == 3'h0 && !d1)
    else $error("serializing instruction not alone");
  a_fold_redirect: assert property (b_go && b_taken && !mis
                                    |=> fetch_addr_o == $past(b_tgt))
    else $error("taken branch did not redirect fetch");
  a_pred_bit: assert property (b_go && b_unres
                               |=> state == ST_SPEC && pend_pred == $past(b_ent.word[PRED_BIT]))
    else $error("prediction not from encoding bit");
  a_no_br_issue: assert property (disp_o[0].valid |-> !disp_o[0].word[CLS_MSB])
    else $error("branch took an execution slot");
  a_spec_hold: assert property (disp_o[0].valid && disp_o[0].spec |-> wb_hold_o)
    else $error("speculative work without hold");
  a_spec_branch: assert property (state == ST_SPEC |-> !b_go)
    else $error("branch issued on speculative path");
  a_release_ok: assert property (res_ok |=> !wb_hold_o ##1 !flush_o)
    else $error("hold not released on correct path");
  a_mis_flush: assert property (mis |=> flush_o && q_cnt == 3'h0
                                && fetch_addr_o == $past(alt_pc))
    else $error("mispredict not flushed and redirected");
  a_issue_limit: assert property (pop_cnt <= 2'(disp_n) + 2'h1 && disp_n <= 2'h2)
    else $error("issue above two plus one branch");
  a_cq_bound: assert property (cq_cnt <= 3'(CQ_DEPTH))
    else $error("more than five in execution");
  a_cq_stall: assert property (cq_cnt == 3'(CQ_DEPTH) |-> !d0)
    else $error("dispatch with completion queue full");
  a_flush_empty: assert property (b_go && b_taken |=> q_cnt == 3'h0)
    else $error("flush left entries");
  a_redir_next: assert property (mis |-> ##1 fetch_req_o)
    else $error("no fetch request after redirect");

  c_dual: cover property (disp_o[0].valid && disp_o[1].valid);
  c_fold: cover property (b_go && !b_unres && d0);
  c_mis: cover property (mis);
  c_ok: cover property (res_ok ##1 disp_o[0].valid);
endmodule

// [bench/ifd_partner.sv]
// Far-side model: instruction cache answering from a small program memory, and the
// ready lines of the five reservation stations.
// Assumes the bench loads mem while the unit is held in reset.
`timescale 1ns/1ps
module ifd_partner (
  input  wire logic             clk_i,
  input  wire logic             fetch_req_i,
  input  wire logic [31:0]      fetch_addr_i,
  input  wire logic             slow_i,
  input  wire logic [4:0]       station_en_i,
  output      logic             ic_valid_o,
  output      logic [1:0]       ic_cnt_o,
  output      logic [31:0]      ic_addr_o,
  output      logic [1:0][31:0] ic_word_o,
  output      logic [4:0]       rs_ready_o
);
  import ifd_pkg::*;
  logic [31:0] mem [64];
  logic        phase = 1'h0;
  logic        live;
  logic [5:0]  idx0;
  logic [5:0]  idx1;

  // Slow mode answers only every other cycle
  always_ff @(posedge clk_i) begin
    phase <= ~phase;
  end

  assign live         = fetch_req_i & (~slow_i | phase);
  assign idx0         = fetch_addr_i[7:2];
  assign idx1         = idx0 + 6'h01;
  assign ic_valid_o   = live;
  assign ic_cnt_o     = 2'h2;
  assign ic_addr_o    = fetch_addr_i;
  // Idle data lines show the inverse so stale words are never mistaken for an answer
  assign ic_word_o[0] = live ? mem[idx0] : ~mem[idx0];
  assign ic_word_o[1] = live ? mem[idx1] : ~mem[idx1];
  assign rs_ready_o   = station_en_i;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the instruction fetch and dispatch unit.
// Assumes the partner model stands in for the icache and the execution units.
`timescale 1ns/1ps
module testbench;
  import ifd_pkg::*;
  logic             clk_i     = 1'h0;
  logic             nrst_i    = 1'h0;
  logic             ic_valid;
  logic [1:0]       ic_cnt;
  logic [31:0]      ic_addr;
  logic [1:0][31:0] ic_word;
  logic             fetch_req_o;
  logic [31:0]      fetch_addr_o;
  logic [4:0]       rs_ready;
  logic [4:0]       st_en     = 5'h00;
  logic             slow      = 1'h0;
  logic [31:0]      gpr_busy  = 32'h0000_0000;
  logic             cond_busy = 1'h0;
  logic             cond_true = 1'h0;
  logic             res_valid = 1'h0;
  logic             res_taken = 1'h0;
  logic [1:0]       retire    = 2'h0;
  ifd_disp_t [1:0]  disp_o;
  logic             wb_hold_o;
  logic             flush_o;
  ifd_disp_t        log_q[$];
  int               cyc_q[$];
  int               cyc         = 0;
  int               fail_count  = 0;
  int               comparisons = 0;

  ifd_partner partner (.clk_i(clk_i), .fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o),
    .slow_i(slow), .station_en_i(st_en), .ic_valid_o(ic_valid), .ic_cnt_o(ic_cnt),
    .ic_addr_o(ic_addr), .ic_word_o(ic_word), .rs_ready_o(rs_ready));

  ifd_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ic_valid_i(ic_valid), .ic_cnt_i(ic_cnt),
    .ic_addr_i(ic_addr), .ic_word_i(ic_word), .fetch_req_o(fetch_req_o),
    .fetch_addr_o(fetch_addr_o), .rs_ready_i(rs_ready), .gpr_busy_i(gpr_busy),
    .fpr_busy_i(32'h0000_0000), .cond_busy_i(cond_busy), .cond_true_i(cond_true),
    .resolve_valid_i(res_valid), .resolve_taken_i(res_taken), .retire_cnt_i(retire),
    .disp_o(disp_o), .wb_hold_o(wb_hold_o), .flush_o(flush_o));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] op(input ifd_cls_t c, input logic [4:0] d, input logic [4:0] a);
    op = {c, 2'h0, d, a, 17'h00000};
  endfunction

  function automatic logic [31:0] br(input ifd_cls_t c, input logic p, input logic [11:0] off);
    br = {c, p, 16'h0000, off};
  endfunction

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  // Dispatch log, stamped with the cycle it appeared in
  always @(negedge clk_i) begin
    cyc++;
    if (disp_o[1].valid === 1'h1 && disp_o[0].valid !== 1'h1) check(1'b0, "slot1 alone");
    for (int s = 0; s < 2; s++) begin
      if (disp_o[s].valid === 1'h1) begin
        log_q.push_back(disp_o[s]);
        cyc_q.push_back(cyc);
      end
    end
  end

  // Reset mid-run with a halting program: every word a jump to itself
  task automatic restart(input logic [4:0] en, input logic sl);
    @(posedge clk_i);
    nrst_i    <= 1'h0;
    st_en     <= en;
    slow      <= sl;
    gpr_busy  <= 32'h0000_0000;
    cond_busy <= 1'h0;
    cond_true <= 1'h0;
    for (int i = 0; i < 64; i++) partner.mem[i] = br(CLS_JUMP, 1'h0, 12'h000);
    repeat (3) @(posedge clk_i);
    log_q.delete();
    cyc_q.delete();
    nrst_i <= 1'h1;
  endtask

  task automatic wait_log(input int n);
    int k = 0;
    while (log_q.size() < n && k < 60) begin
      @(negedge clk_i);
      k++;
    end
    repeat (6) @(negedge clk_i);
  endtask

  task automatic test_fill();
    int k = 0;
    restart(5'h00, 1'h0);
    for (int i = 0; i < 16; i++) partner.mem[i] = op(CLS_INT, 5'(i + 1), 5'h00);
    while (fetch_addr_o === 32'h0000_0000 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    check(fetch_addr_o === 32'h0000_0008, "first fetch not two words");
    repeat (10) @(negedge clk_i);
    check(fetch_addr_o === 32'h0000_0018, "queue not capped at six");
    check(log_q.size() === 0, "dispatch to unready station");
    @(posedge clk_i);
    st_en <= 5'h1f;
    wait_log(5);
    check(log_q.size() === 5, "completion limit not kept");
    @(posedge clk_i);
    retire <= 2'h2;
    @(posedge clk_i);
    retire <= 2'h0;
    wait_log(7);
    check(log_q.size() === 7, "in-flight count wrong");
    for (int i = 0; i < log_q.size(); i++) check(log_q[i].pc === 32'(4 * i), "order");
    check(log_q[0].station === RS_INT0 && log_q[1].station === RS_INT1, "station");
    $display("test fill done");
  endtask

  task automatic test_dep();
    restart(5'h1f, 1'h1);
    partner.mem[0] = op(CLS_INT, 5'h03, 5'h00);
    partner.mem[1] = op(CLS_INT, 5'h05, 5'h03);
    partner.mem[2] = op(CLS_LDST, 5'h06, 5'h07) | 32'h0800_0000;
    @(posedge clk_i);
    gpr_busy <= 32'h0000_0080;
    wait_log(2);
    check(log_q.size() === 2 && cyc_q[1] !== cyc_q[0], "hazard not split");
    @(posedge clk_i);
    gpr_busy <= 32'h0000_0000;
    wait_log(3);
    check(log_q.size() === 2, "serializing op did not wait");
    @(posedge clk_i);
    retire <= 2'h2;
    @(posedge clk_i);
    retire <= 2'h0;
    wait_log(3);
    check(log_q.size() === 3 && log_q[2].station === RS_LDST, "busy stall");
    $display("test dependency done");
  endtask

  task automatic test_fold();
    restart(5'h1f, 1'h0);
    partner.mem[0]  = op(CLS_INT, 5'h01, 5'h00);
    partner.mem[1]  = br(CLS_JUMP, 1'h0, 12'h00f);
    partner.mem[16] = br(CLS_CBR, 1'h0, 12'h008);
    partner.mem[24] = op(CLS_LDST, 5'h02, 5'h00);
    @(posedge clk_i);
    cond_true <= 1'h1;
    wait_log(2);
    check(log_q.size() === 2 && log_q[1].pc === 32'h0000_0060, "fold");
    check(wb_hold_o === 1'h0, "known branch was predicted");
    $display("test fold done");
  endtask

  task automatic test_spec(input logic pred, input logic taken);
    logic [31:0] good;
    good = taken ? 32'h0000_0020 : 32'h0000_0004;
    restart(5'h1f, 1'h0);
    partner.mem[0] = br(CLS_CBR, pred, 12'h008);
    partner.mem[1] = op(CLS_INT, 5'h01, 5'h00);
    partner.mem[2] = op(CLS_LDST, 5'h02, 5'h00);
    partner.mem[8] = op(CLS_INT, 5'h03, 5'h00);
    partner.mem[9] = op(CLS_LDST, 5'h04, 5'h00);
    @(posedge clk_i);
    cond_busy <= 1'h1;
    wait_log(2);
    check(wb_hold_o === 1'h1, "write-back not held");
    check(log_q.size() === 2 && log_q[0].spec === 1'h1 && log_q[1].spec === 1'h1, "spec");
    check(log_q[0].pc === (pred ? 32'h0000_0020 : 32'h0000_0004), "prediction");
    log_q.delete();
    @(posedge clk_i);
    res_valid <= 1'h1;
    res_taken <= taken;
    cond_busy <= 1'h0;
    @(posedge clk_i);
    res_valid <= 1'h0;
    #1;
    check(flush_o === (pred ^ taken), "flush pulse");
    check(wb_hold_o === 1'h0, "hold not released");
    if (pred != taken) begin
      check(fetch_addr_o === good, "redirect");
      wait_log(1);
      check(log_q.size() > 0 && log_q[0].pc === good && log_q[0].spec === 1'h0, "resume");
    end
    $display("test speculation done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #60000;
    fail_count++;
    $display("CHECK FAILED at %0t ns: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    check(fetch_req_o === 1'h0 && flush_o === 1'h0 && wb_hold_o === 1'h0, "reset values");
    check(disp_o === '0 && fetch_addr_o === 32'h0000_0000, "reset dispatch");
    test_fill();
    test_dep();
    test_fold();
    test_spec(1'h0, 1'h1);
    test_spec(1'h1, 1'h0);
    test_spec(1'h1, 1'h1);
    print_verdict();
  end
endmodule
